// >>> core/kr_pcs_tp_regs.svh
// Register offsets, field positions, reset values and fixed constants of the
// test-pattern block. Assumes 16-bit Clause 45 registers in one device address.
`ifndef KR_PCS_TP_REGS_SVH
`define KR_PCS_TP_REGS_SVH

// -----------------------------------------------------------------------------
// Device address and register offsets
// -----------------------------------------------------------------------------
`define TP_DEVAD 5'h03
`define TP_SEED_A0 16'h0022
`define TP_SEED_A1 16'h0023
`define TP_SEED_A2 16'h0024
`define TP_SEED_A3 16'h0025
`define TP_SEED_B0 16'h0026
`define TP_SEED_B1 16'h0027
`define TP_SEED_B2 16'h0028
`define TP_SEED_B3 16'h0029
`define TP_CONTROL 16'h002a
`define TP_ERR_COUNT 16'h002b
`define TP_VS_CONTROL 16'h8000
`define TP_VS_STATUS 16'h8010

// -----------------------------------------------------------------------------
// Field positions and reset values
// -----------------------------------------------------------------------------
`define TP_SEED_TOP_W 10
`define TP_CTRL_W 6
`define TP_CTRL_RESET 6'h00
`define TP_SQ_LEN_LSB 4
`define TP_SQ_LEN_RESET 4'hb
`define TP_ERR_FLAG_BIT 8
`define TP_SEED_RESET 58'h0
`define TP_PRBS_INIT 31'h7fffffff
`define TP_CNT_MAX 16'hffff

`endif

// >>> core/kr_pcs_tp_pkg.sv
// Types shared by the test-pattern block: management request and answer, and
// the control word layout. Assumes a Clause 45 frame decoder in front.
package kr_pcs_tp_pkg;

   // -------------------------------------------------------------------------
   // Management access
   // -------------------------------------------------------------------------
   typedef struct packed {
      logic valid;
      logic write;
      logic [4:0] devad;
      logic [15:0] regad;
      logic [15:0] wdata;
   } mgmt_req_t;

   typedef struct packed {
      logic valid;
      logic hit;
      logic [15:0] rdata;
   } mgmt_rsp_t;

   // -------------------------------------------------------------------------
   // Control word, bit 5 down to bit 0
   // -------------------------------------------------------------------------
   typedef struct packed {
      logic rx_prbs_check_on;
      logic tx_prbs_gen_on;
      logic tx_pattern_gen_on;
      logic rx_pattern_check_on;
      logic pattern_kind_select;
      logic data_pattern_select;
   } ctrl_t;

endpackage

// >>> core/kr_pcs_test_pattern_ctrl.sv
// Test-pattern generation and checking for a 10GBASE-R PCS, with its seed,
// control and error-count registers. Assumes a management frame decoder on the
// same clock presents one request per cycle, and that both data paths are
// word-wide on the PCS clock, bit 0 first in time.
`timescale 1ns/1ps
`default_nettype none
`include "kr_pcs_tp_regs.svh"

// How it works
// [RULE1] Seed A is 58 bits in four words; top word holds bits 57:48.
// [RULE2] Seed B is 58 bits in four consecutive words, lowest word bits 15:0.
// [RULE3] Upper six bits of top seed words and control bits 15:6 read zero.
// [RULE4] Control bit 5 turns on PRBS31 checking of received data.
// [RULE5] Control bit 4 sends PRBS31 instead of normal transmit traffic.
// [RULE6] Control bit 3 sends the selected test pattern instead of data.
// [RULE7] Control bit 2 checks received data against the selected pattern; the code checks only the seeded pattern, none for square wave.
// [RULE8] Control bit 1 picks square wave when set, seeded pattern when clear.
// [RULE9] Control bit 0 picks zeros data when set, LF data when clear.
// [RULE10] All control bits are zero after reset, both paths normal.
// [RULE11] A 16-bit error counter counts test errors and clears when read.
// [RULE12] PRBS31 checking counts each received byte with any bit wrong once.
// [RULE13] The counter follows whichever test mode the control word selects; the code counts nothing when square wave is selected for receive checking.
// [RULE14] Every register answers only accesses to device address 3.
// [RULE15] Square wave is a run of zeros then ones, run length default 11.
// [RULE16] A pseudo-random check error sets a latched flag cleared by read.
// [RULE17] The error counter saturates at its maximum until read.
// [RULE18] Generators and checkers load their seeds when enabled.
module kr_pcs_test_pattern_ctrl
   import kr_pcs_tp_pkg::*;
#(
   parameter int DATA_W = 64,
   parameter logic [DATA_W-1:0] LF_DATA = {(DATA_W/8){8'h55}}
) (
   input wire logic clock,
   input wire logic srst,
   input wire mgmt_req_t mgmt_req,
   output mgmt_rsp_t mgmt_rsp,
   input wire logic [DATA_W-1:0] tx_data_in,
   output logic [DATA_W-1:0] tx_data_out,
   input wire logic [DATA_W-1:0] rx_data_in,
   output logic pattern_error_flag
);

   localparam int NBYTES = DATA_W / 8;

   // The PRBS31 checker needs a whole history of 31 bits in one word.
   if (DATA_W < 32 || DATA_W % 8 != 0) begin : g_width_check
      $error("DATA_W must be a multiple of 8 and at least 32");
   end

   // -------------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------------
   typedef struct packed {
      logic [57:0] seed_a;
      logic [57:0] seed_b;
      ctrl_t ctrl;
      ctrl_t ctrl_prev;
      logic [3:0] sq_len;
      logic [15:0] err_cnt;
      logic err_flag;
      logic [57:0] tx_scr;
      logic [30:0] tx_prbs;
      logic [3:0] sq_cnt;
      logic sq_level;
      logic [57:0] rx_scr;
      logic [30:0] rx_hist;
      logic rx_warm;
      logic [DATA_W-1:0] tx_out;
      mgmt_rsp_t rsp;
   } state_t;

   state_t st;
   state_t next_st;

   // -------------------------------------------------------------------------
   // Pattern engines, one word per call
   // -------------------------------------------------------------------------
   function automatic logic [58+DATA_W-1:0] scr_run(input logic [57:0] s,
                                                     input logic [DATA_W-1:0] d);
      logic [57:0] t;
      logic [DATA_W-1:0] o;
      logic b;
      t = s;
      o = '0;
      for (int i = 0; i < DATA_W; i++) begin
         b = d[i] ^ t[38] ^ t[57];
         o[i] = b;
         t = {t[56:0], b};
      end
      return {t, o};
   endfunction

   function automatic logic [31+DATA_W-1:0] prbs_run(input logic [30:0] s);
      logic [30:0] t;
      logic [DATA_W-1:0] o;
      logic b;
      t = s;
      o = '0;
      for (int i = 0; i < DATA_W; i++) begin
         b = t[30] ^ t[27];
         o[i] = b;
         t = {t[29:0], b};
      end
      return {t, o};
   endfunction

   // Self-synchronising: the prediction comes from received bits, so a slip
   // costs one burst of errors rather than a permanent mismatch.
   function automatic logic [31+DATA_W-1:0] prbs_check(input logic [30:0] h,
                                                        input logic [DATA_W-1:0] d);
      logic [30:0] t;
      logic [DATA_W-1:0] e;
      t = h;
      e = '0;
      for (int i = 0; i < DATA_W; i++) begin
         e[i] = d[i] ^ t[30] ^ t[27];
         t = {t[29:0], d[i]};
      end
      return {t, e};
   endfunction

   // A run length of zero is served as one, since the field allows it.
   function automatic logic [5+DATA_W-1:0] sq_run(input logic [3:0] c0, input logic l0,
                                                   input logic [3:0] len);
      logic [3:0] c;
      logic [3:0] n;
      logic l;
      logic [DATA_W-1:0] o;
      c = c0;
      l = l0;
      n = (len == 4'h0) ? 4'h1 : len;
      o = '0;
      for (int i = 0; i < DATA_W; i++) begin
         o[i] = l;
         if (c == 4'(n - 4'h1)) begin
            c = 4'h0;
            l = ~l;
         end else begin
            c = 4'(c + 4'h1);
         end
      end
      return {c, l, o};
   endfunction

   // -------------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------------
   logic acc_hit;
   logic cnt_clear;
   logic flag_clear;
   logic [15:0] nbad;
   logic [16:0] sum;
   logic [15:0] rd;
   logic [58+DATA_W-1:0] scr_res;
   logic [31+DATA_W-1:0] prbs_res;
   logic [5+DATA_W-1:0] sq_res;
   logic [DATA_W-1:0] dp_word;
   ctrl_t rise;

   always_comb begin
      next_st = st;
      next_st.rsp = '0;
      next_st.ctrl_prev = st.ctrl;
      cnt_clear = 1'b0;
      flag_clear = 1'b0;
      nbad = 16'h0000;
      sum = 17'h00000;
      rd = 16'h0000;
      scr_res = '0;
      prbs_res = '0;
      sq_res = '0;
      rise = st.ctrl & ~st.ctrl_prev;
      // [RULE9] data pattern choice
      dp_word = st.ctrl.data_pattern_select ? '0 : LF_DATA;

      // [RULE14] device address decode
      acc_hit = mgmt_req.valid && (mgmt_req.devad == `TP_DEVAD);
      if (acc_hit) begin
         // [RULE1] [RULE2] [RULE3] seed and control word mapping
         if (mgmt_req.regad == `TP_SEED_A0) begin
            rd = st.seed_a[15:0];
         end else if (mgmt_req.regad == `TP_SEED_A1) begin
            rd = st.seed_a[31:16];
         end else if (mgmt_req.regad == `TP_SEED_A2) begin
            rd = st.seed_a[47:32];
         end else if (mgmt_req.regad == `TP_SEED_A3) begin
            rd = {6'h00, st.seed_a[57:48]};
         end else if (mgmt_req.regad == `TP_SEED_B0) begin
            rd = st.seed_b[15:0];
         end else if (mgmt_req.regad == `TP_SEED_B1) begin
            rd = st.seed_b[31:16];
         end else if (mgmt_req.regad == `TP_SEED_B2) begin
            rd = st.seed_b[47:32];
         end else if (mgmt_req.regad == `TP_SEED_B3) begin
            rd = {6'h00, st.seed_b[57:48]};
         end else if (mgmt_req.regad == `TP_CONTROL) begin
            rd = {10'h000, st.ctrl};
         end else if (mgmt_req.regad == `TP_ERR_COUNT) begin
            rd = st.err_cnt;
            // [RULE11] clear on read
            cnt_clear = !mgmt_req.write;
         end else if (mgmt_req.regad == `TP_VS_CONTROL) begin
            rd = {8'h00, st.sq_len, 4'h0};
         end else if (mgmt_req.regad == `TP_VS_STATUS) begin
            rd = {7'h00, st.err_flag, 8'h00};
            flag_clear = !mgmt_req.write;
         end else begin
            acc_hit = 1'b0;
         end
      end
      next_st.rsp.valid = mgmt_req.valid;
      next_st.rsp.hit = acc_hit;
      next_st.rsp.rdata = (acc_hit && !mgmt_req.write) ? rd : 16'h0000;

      if (acc_hit && mgmt_req.write) begin
         if (mgmt_req.regad == `TP_SEED_A0) begin
            next_st.seed_a[15:0] = mgmt_req.wdata;
         end else if (mgmt_req.regad == `TP_SEED_A1) begin
            next_st.seed_a[31:16] = mgmt_req.wdata;
         end else if (mgmt_req.regad == `TP_SEED_A2) begin
            next_st.seed_a[47:32] = mgmt_req.wdata;
         end else if (mgmt_req.regad == `TP_SEED_A3) begin
            next_st.seed_a[57:48] = mgmt_req.wdata[`TP_SEED_TOP_W-1:0];
         end else if (mgmt_req.regad == `TP_SEED_B0) begin
            next_st.seed_b[15:0] = mgmt_req.wdata;
         end else if (mgmt_req.regad == `TP_SEED_B1) begin
            next_st.seed_b[31:16] = mgmt_req.wdata;
         end else if (mgmt_req.regad == `TP_SEED_B2) begin
            next_st.seed_b[47:32] = mgmt_req.wdata;
         end else if (mgmt_req.regad == `TP_SEED_B3) begin
            next_st.seed_b[57:48] = mgmt_req.wdata[`TP_SEED_TOP_W-1:0];
         end else if (mgmt_req.regad == `TP_CONTROL) begin
            next_st.ctrl = ctrl_t'(mgmt_req.wdata[`TP_CTRL_W-1:0]);
         end else if (mgmt_req.regad == `TP_VS_CONTROL) begin
            next_st.sq_len = mgmt_req.wdata[`TP_SQ_LEN_LSB +: 4];
         end
      end

      // Transmit path; PRBS31 takes precedence over the other test pattern.
      if (st.ctrl.tx_prbs_gen_on) begin
         // [RULE5] [RULE18] PRBS31 generation
         prbs_res = prbs_run(rise.tx_prbs_gen_on ? `TP_PRBS_INIT : st.tx_prbs);
         next_st.tx_prbs = prbs_res[31+DATA_W-1:DATA_W];
         next_st.tx_out = prbs_res[DATA_W-1:0];
      end else if (st.ctrl.tx_pattern_gen_on) begin
         // [RULE6] [RULE8] pattern kind
         if (st.ctrl.pattern_kind_select) begin
            // [RULE15] square wave runs
            sq_res = sq_run(rise.tx_pattern_gen_on ? 4'h0 : st.sq_cnt,
                            rise.tx_pattern_gen_on ? 1'b0 : st.sq_level, st.sq_len);
            next_st.sq_cnt = sq_res[5+DATA_W-1:DATA_W+1];
            next_st.sq_level = sq_res[DATA_W];
            next_st.tx_out = sq_res[DATA_W-1:0];
         end else begin
            // [RULE18] seed A loads on enable
            scr_res = scr_run(rise.tx_pattern_gen_on ? st.seed_a : st.tx_scr, dp_word);
            next_st.tx_scr = scr_res[58+DATA_W-1:DATA_W];
            next_st.tx_out = scr_res[DATA_W-1:0];
         end
      end else begin
         next_st.tx_out = tx_data_in;
      end

      // Receive checking; the first PRBS31 word only fills the history.
      next_st.rx_warm = 1'b0;
      if (st.ctrl.rx_prbs_check_on) begin
         // [RULE4] [RULE12] errored bytes
         prbs_res = prbs_check(rise.rx_prbs_check_on ? 31'h0 : st.rx_hist, rx_data_in);
         next_st.rx_hist = prbs_res[31+DATA_W-1:DATA_W];
         next_st.rx_warm = 1'b1;
         if (st.rx_warm && !rise.rx_prbs_check_on) begin
            for (int k = 0; k < NBYTES; k++) begin
               if (|prbs_res[k*8 +: 8]) begin
                  nbad = 16'(nbad + 16'h0001);
               end
            end
         end
      end else if (st.ctrl.rx_pattern_check_on && !st.ctrl.pattern_kind_select) begin
         // [RULE7] [RULE18] seed B loads on enable
         scr_res = scr_run(rise.rx_pattern_check_on ? st.seed_b : st.rx_scr, dp_word);
         next_st.rx_scr = scr_res[58+DATA_W-1:DATA_W];
         if (scr_res[DATA_W-1:0] != rx_data_in) begin
            nbad = 16'h0001;
         end
      end

      // [RULE13] [RULE17] count of the active mode, saturating
      sum = {1'b0, cnt_clear ? 16'h0000 : st.err_cnt} + {1'b0, nbad};
      next_st.err_cnt = sum[16] ? `TP_CNT_MAX : sum[15:0];
      // [RULE16] latched flag, a new error beats the read clear
      next_st.err_flag = (nbad != 16'h0000) || (st.err_flag && !flag_clear);
   end

   // [RULE10] reset values
   always_ff @(posedge clock) begin
      if (srst) begin
         st <= '0;
         st.sq_len <= `TP_SQ_LEN_RESET;
      end else begin
         st <= next_st;
      end
   end

   assign mgmt_rsp = st.rsp;
   assign tx_data_out = st.tx_out;
   assign pattern_error_flag = st.err_flag;

   // -------------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);

   property p_reset_ctrl;
      @(posedge clock) disable iff (1'b0) srst |=> (st.ctrl == `TP_CTRL_RESET && !st.err_flag);
   endproperty
   a_reset_ctrl: assert property (p_reset_ctrl) else $error("control not clear after reset"); // [RULE10]

   property p_top_seed_zero;
      mgmt_req.valid && !mgmt_req.write && mgmt_req.devad == `TP_DEVAD &&
      (mgmt_req.regad == `TP_SEED_A3 || mgmt_req.regad == `TP_SEED_B3)
      |=> mgmt_rsp.hit && mgmt_rsp.rdata[15:10] == 6'h00;
   endproperty
   a_top_seed_zero: assert property (p_top_seed_zero) else $error("seed top bits not zero"); // [RULE3]

   property p_other_devad;
      mgmt_req.valid && mgmt_req.devad != `TP_DEVAD |=> !mgmt_rsp.hit && mgmt_rsp.valid;
   endproperty
   a_other_devad: assert property (p_other_devad) else $error("answered foreign device"); // [RULE14]

   property p_read_clears;
      mgmt_req.valid && !mgmt_req.write && mgmt_req.devad == `TP_DEVAD &&
      mgmt_req.regad == `TP_ERR_COUNT && nbad == 16'h0000 |=> st.err_cnt == 16'h0000;
   endproperty
   a_read_clears: assert property (p_read_clears) else $error("counter not cleared by read"); // [RULE11]

   property p_saturate;
      st.err_cnt == `TP_CNT_MAX && !cnt_clear |=> st.err_cnt == `TP_CNT_MAX;
   endproperty
   a_saturate: assert property (p_saturate) else $error("counter wrapped"); // [RULE17]

   property p_tx_normal;
      !st.ctrl.tx_prbs_gen_on && !st.ctrl.tx_pattern_gen_on |=> tx_data_out == $past(tx_data_in);
   endproperty
   a_tx_normal: assert property (p_tx_normal) else $error("normal transmit corrupted"); // [RULE6]

   property p_prbs_bytes;
      st.ctrl.rx_prbs_check_on && st.rx_warm && !rise.rx_prbs_check_on && !cnt_clear &&
      st.err_cnt < 16'hff00 |=> st.err_cnt <= $past(st.err_cnt) + 16'(NBYTES);
   endproperty
   a_prbs_bytes: assert property (p_prbs_bytes) else $error("more than one count per byte"); // [RULE12]

   logic [58+DATA_W-1:0] seed_probe;
   assign seed_probe = scr_run(st.seed_a, dp_word);
   property p_seed_load;
      rise.tx_pattern_gen_on && !st.ctrl.tx_prbs_gen_on && !st.ctrl.pattern_kind_select
      |=> tx_data_out == $past(seed_probe[DATA_W-1:0]);
   endproperty
   a_seed_load: assert property (p_seed_load) else $error("seed A not loaded"); // [RULE18]

   property p_flag_set;
      nbad != 16'h0000 |=> pattern_error_flag ##1 (pattern_error_flag || $past(flag_clear));
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("error flag not latched"); // [RULE16]

endmodule
`default_nettype wire

// >>> verification/mgmt_station.sv
// Management station model: turns one command into one register access
// and returns the registered answer.
// Assumes the block answers one cycle after it takes a request.
`timescale 1ns/1ps
`default_nettype none
module mgmt_station
   import kr_pcs_tp_pkg::*;
(
   input wire logic clock,
   input wire logic srst,
   input wire mgmt_req_t cmd,
   output mgmt_req_t mgmt_req,
   input wire mgmt_rsp_t mgmt_rsp,
   output mgmt_rsp_t answer
);
   // ---------------------------------------------------------------------
   // Request and answer
   // ---------------------------------------------------------------------
   // device address carried
   always_ff @(posedge clock) begin
      if (srst) begin
         mgmt_req <= '0;
      end else if (cmd.valid) begin
         mgmt_req <= cmd;
      end else begin
         // Between accesses the fields carry nothing, so they toggle to keep
         // the block from leaning on stale values.
         mgmt_req <= {1'b0, ~mgmt_req[37:0]};
      end
   end

   always_ff @(posedge clock) begin
      answer <= mgmt_rsp;
   end
endmodule
`default_nettype wire

// >>> verification/tb.sv
// Self-checking bench: register accesses through the station model,
// transmit patterns and receive error counting with a looped data path.
// Assumes one clock shared by the block and the station model.
`timescale 1ns/1ps
`default_nettype none
module tb
   import kr_pcs_tp_pkg::*;
;
   logic clock = 1'b0;
   logic srst;
   logic loop_on;
   logic flag;
   logic [63:0] tx_in, tx_out, rx_in, rx_fix, flip, w0, w1;
   logic [15:0] pass_ctrl [5] = '{16'h0000, 16'h0001, 16'h0002, 16'h0004, 16'h0020};
   mgmt_req_t cmd, req;
   mgmt_rsp_t rsp, ans;
   int err_count = 0;
   int n_tests = 0;
   logic [15:0] exp_w;

   always #2 clock = ~clock;
   assign rx_in = loop_on ? (tx_out ^ flip) : rx_fix;

   kr_pcs_test_pattern_ctrl #(.DATA_W(64)) i_dut (
      .clock(clock), .srst(srst), .mgmt_req(req), .mgmt_rsp(rsp),
      .tx_data_in(tx_in), .tx_data_out(tx_out), .rx_data_in(rx_in),
      .pattern_error_flag(flag));

   mgmt_station i_station (
      .clock(clock), .srst(srst), .cmd(cmd), .mgmt_req(req), .mgmt_rsp(rsp),
      .answer(ans));

   // ---------------------------------------------------------------------
   // Access and compare tasks
   // ---------------------------------------------------------------------
   task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic access(input logic w, input logic [4:0] da, input logic [15:0] ra,
                         input logic [15:0] wd);
      int n;
      n = 0;
      @(posedge clock);
      cmd <= {1'b1, w, da, ra, wd};
      @(posedge clock);
      cmd.valid <= 1'b0;
      while (ans.valid !== 1'b1 && n < 20) begin
         @(posedge clock);
         n++;
      end
      if (n >= 20) chk("answer", 1, 0);
   endtask

   task automatic wr_reg(input logic [15:0] ra, input logic [15:0] wd);
      access(1'b1, 5'h03, ra, wd);
   endtask

   task automatic rc(input logic [15:0] ra, input logic [15:0] exp);
      access(1'b0, 5'h03, ra, 16'h0000);
      chk("hit", 1, ans.hit);
      chk($sformatf("reg %h", ra), exp, ans.rdata);
   endtask

   task automatic tx_step(input logic [63:0] d);
      @(posedge clock);
      tx_in <= d;
      repeat (2) @(posedge clock);
   endtask

   // A square wave of run length len has period 2*len, each half inverted.
   task automatic sq_chk(input int len);
      int bad;
      logic [127:0] s;
      bad = 0;
      repeat (4) @(posedge clock);
      s[63:0] = tx_out;
      @(posedge clock);
      s[127:64] = tx_out;
      for (int i = 2 * len; i < 128; i++)
         if (s[i] !== s[i - 2 * len] || s[i] === s[i - len]) bad++;
      chk("square", 0, 64'(bad));
   endtask

   // Control is cleared first so the enable rises and seeds reload.
   task automatic pr_word(input logic [15:0] c, output logic [63:0] w);
      wr_reg(16'h002a, 16'h0000);
      wr_reg(16'h002a, c);
      repeat (3) @(posedge clock);
      w = tx_out;
   endtask

   task automatic complete_run;
      if (err_count == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------------
   initial begin
      srst = 1'b1;
      cmd = '0;
      tx_in = 64'h0123456789abcdef;
      rx_fix = '0;
      flip = '0;
      loop_on = 1'b0;
      repeat (6) @(posedge clock);
      srst <= 1'b0;
      for (int i = 0; i < 10; i++) rc(16'h0022 + 16'(i), 16'h0000);
      rc(16'h8000, 16'h00b0);
      rc(16'h8010, 16'h0000);
      for (int i = 0; i < 8; i++) wr_reg(16'h0022 + 16'(i), 16'hfff0 | 16'(i));
      for (int i = 0; i < 8; i++) begin
         exp_w = (i % 4 == 3) ? (16'h03f0 | 16'(i)) : (16'hfff0 | 16'(i));
         rc(16'h0022 + 16'(i), exp_w);
      end
      wr_reg(16'h002a, 16'hffff);
      rc(16'h002a, 16'h003f);
      access(1'b1, 5'h01, 16'h002a, 16'h0000);
      chk("miss hit", 0, ans.hit);
      access(1'b0, 5'h01, 16'h002a, 16'h0000);
      chk("miss data", 0, ans.rdata);
      rc(16'h002a, 16'h003f);
      access(1'b0, 5'h03, 16'h0030, 16'h0000);
      chk("unmapped hit", 0, ans.hit);
      foreach (pass_ctrl[k]) begin
         wr_reg(16'h002a, pass_ctrl[k]);
         tx_step(64'h0123456789abcdef ^ 64'(k));
         chk("pass", tx_in, tx_out);
      end
      wr_reg(16'h002a, 16'h0010);
      tx_step(64'h0f0f0f0f0f0f0f0f);
      chk("prbs tx", 1, tx_out !== tx_in);
      wr_reg(16'h002a, 16'h000a);
      sq_chk(11);
      wr_reg(16'h8000, 16'h0030);
      rc(16'h8000, 16'h0030);
      sq_chk(3);
      pr_word(16'h0008, w0);
      pr_word(16'h0008, w1);
      chk("pr reload", w0, w1);
      chk("pr not data", 1, w0 !== tx_in);
      pr_word(16'h0009, w1);
      chk("pr data sel", 1, w0 !== w1);
      wr_reg(16'h0022, 16'h1234);
      pr_word(16'h0008, w1);
      chk("pr seed", 1, w0 !== w1);
      wr_reg(16'h002a, 16'h0000);
      // The seeded check step of the pass loop met a zero input, so errors and the flag are up.
      access(1'b0, 5'h03, 16'h002b, 16'h0000);
      chk("pass errors", 1, ans.rdata != 0);
      rc(16'h8010, 16'h0100);
      rc(16'h8010, 16'h0000);
      rx_fix <= 64'hdeadbeef00c0ffee;
      wr_reg(16'h002a, 16'h0004);
      repeat (20) @(posedge clock);
      wr_reg(16'h002a, 16'h0000);
      chk("flag", 1, flag);
      access(1'b0, 5'h03, 16'h002b, 16'h0000);
      chk("seeded errors", 1, ans.rdata != 0 && ans.rdata <= 40);
      rc(16'h8010, 16'h0100);
      chk("flag clear", 0, flag);
      wr_reg(16'h002a, 16'h0006);
      repeat (20) @(posedge clock);
      wr_reg(16'h002a, 16'h0000);
      rc(16'h002b, 16'h0000);
      loop_on <= 1'b1;
      wr_reg(16'h002a, 16'h0010);
      wr_reg(16'h002a, 16'h0030);
      access(1'b0, 5'h03, 16'h002b, 16'h0000);
      repeat (20) @(posedge clock);
      rc(16'h002b, 16'h0000);
      flip <= 64'h3;
      @(posedge clock);
      flip <= 64'h0;
      repeat (4) @(posedge clock);
      chk("prbs flag", 1, flag);
      rc(16'h002b, 16'h0003);
      rc(16'h002b, 16'h0000);
      loop_on <= 1'b0;
      rx_fix <= '1;
      wr_reg(16'h002a, 16'h0020);
      repeat (17000) @(posedge clock);
      wr_reg(16'h002a, 16'h0000);
      // A write must neither load nor clear the counter.
      wr_reg(16'h002b, 16'h1234);
      rc(16'h002b, 16'hffff);
      rc(16'h002b, 16'h0000);
      complete_run;
   end

   initial begin
      #200000;
      chk("watchdog", 0, 1);
      complete_run;
   end
endmodule
`default_nettype wire
